// file: dv/strap_board_model.sv
// Board strap resistors behind the secondary bus address pins
`timescale 1ns/10ps
module strap_board_model (
    // Strap pattern and host port fitting
    input  wire logic [20:1] strap_pattern,
    input  wire logic        host_port_on,
    // Device side of the pins
    input  wire logic [20:1] pin_drive,
    input  wire logic        pin_oe,
    output logic [20:1]      pin_level
);
    logic [20:1] pulled;
    // Bit 13 is never pulled high on a board without the host port
    always_comb begin
        pulled = strap_pattern;
        pulled[13] = strap_pattern[13] & host_port_on;
    end
    // Driven pins win, released pins settle to the resistor levels
    assign pin_level = pin_oe ? pin_drive : pulled;
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the reset strap configuration latch
`timescale 1ns/10ps
module tb_top;
    logic                      clk, sys_rst, reg_wr, reg_rd, host_on, oe;
    logic                      le, ai, atm, sp1, rsv;
    logic [3:0]                reg_addr;
    logic [31:0]               reg_wdata, reg_rdata, rd, seed;
    logic [20:1]               strap, pins, pout;
    strap_cfg_pkg::boot_mode_t boot;
    strap_cfg_pkg::clk_sel_t   pck, sck;
    int                        errors, checks_done, cycles;
    reset_strap_config_latch dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .secondary_bus_address_in(pins), .secondary_bus_address_out(pout),
        .secondary_bus_address_oe(oe), .little_endian(le), .boot_mode(boot),
        .primary_bus_clock_source_sel(pck), .secondary_bus_clock_source_sel(sck),
        .host_port_eeprom_autoinit(ai), .atm_cell_port_enable(atm),
        .serial_port_one_enable(sp1), .strap_reserved(rsv));
    strap_board_model board_u (.strap_pattern(strap), .host_port_on(host_on),
        .pin_drive(pout), .pin_oe(oe), .pin_level(pins));
    // Random source
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected status word from the sampled pin levels
    function automatic logic [31:0] exp_status(input logic [20:1] v);
        return {22'h0, (&v[19:18]) | (&v[17:16]) | (&v[15:14]), v[11], v[13],
                v[15:14], v[17:16], v[19:18], v[20]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Reset with a strap pattern, then check the captured fields
    task automatic run_reset(input logic [20:1] v, input logic h);
        logic [20:1] e;
        @(posedge clk);
        sys_rst <= 1'b1;
        strap <= v;
        host_on <= h;
        repeat (5) @(posedge clk);
        chk({31'h0, oe}, 32'h0);
        sys_rst <= 1'b0;
        strap <= ~v; // Pin changes after release must not leak in
        repeat (3) @(posedge clk);
        #1;
        e = v;
        e[13] = v[13] & h;
        chk({22'h0, rsv, atm, ai, sck, pck, boot, le}, exp_status(e));
        chk({31'h0, sp1}, {31'h0, ~e[11]});
        chk({31'h0, oe}, 32'h1);
        rd_reg(4'h0, exp_status(e));
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Timeout guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, errors, checks_done, cycles} = '0;
        sys_rst = 1'b1;
        strap = 20'hFFFFF;
        host_on = 1'b1;
        seed = 32'h351C;
        run_reset(20'hFFFFF, 1'b1);
        run_reset(20'h00000, 1'b1);
        run_reset(20'hA0000, 1'b0);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            run_reset(seed[19:0], seed[20]);
            wr_reg(4'h8, {12'h0, seed[31:12]});
            wr_reg(4'h0, 32'hFFFFFFFF);
            wr_reg(4'hC, 32'hFFFFFFFF);
            rd_reg(4'h8, {12'h0, seed[31:12]});
            rd_reg(4'hC, 32'h0);
            chk({12'h0, pout}, {12'h0, seed[31:12]});
            wr_reg(4'h4, 32'h0);
            rd_reg(4'h4, 32'h0);
            chk({31'h0, oe}, 32'h0);
            wr_reg(4'h4, 32'h1);
        end
        finish_test();
    end
endmodule

// file: verilog/reset_strap_config_latch.sv
// Reset strap configuration latch on the secondary bus address pins
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
module reset_strap_config_latch (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    // Register port
    input  wire logic [strap_cfg_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [31:0]                      reg_rdata,
    // Secondary bus address pins
    input  wire logic [20:1]                 secondary_bus_address_in,
    output logic [20:1]                      secondary_bus_address_out,
    output logic                             secondary_bus_address_oe,
    // Captured configuration
    output logic                             little_endian,
    output strap_cfg_pkg::boot_mode_t        boot_mode,
    output strap_cfg_pkg::clk_sel_t          primary_bus_clock_source_sel,
    output strap_cfg_pkg::clk_sel_t          secondary_bus_clock_source_sel,
    output logic                             host_port_eeprom_autoinit,
    output logic                             atm_cell_port_enable,
    output logic                             serial_port_one_enable,
    output logic                             strap_reserved
);
    logic        drive_q;
    logic [20:1] addr_q;

    // True when a two-bit code is the reserved one
    function automatic logic is_rsvd(input logic [1:0] code);
        is_rsvd = (code == strap_cfg_pkg::CLK_RESERVED);
    endfunction

    // Sample straps every reset cycle; last sample stands at release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            little_endian <= secondary_bus_address_in[strap_cfg_pkg::POS_ENDIAN];
            boot_mode <= strap_cfg_pkg::boot_mode_t'(
                secondary_bus_address_in[strap_cfg_pkg::POS_BOOT_HI:
                                         strap_cfg_pkg::POS_BOOT_LO]);
            primary_bus_clock_source_sel <= strap_cfg_pkg::clk_sel_t'(
                secondary_bus_address_in[strap_cfg_pkg::POS_PRI_HI:
                                         strap_cfg_pkg::POS_PRI_LO]);
            secondary_bus_clock_source_sel <= strap_cfg_pkg::clk_sel_t'(
                secondary_bus_address_in[strap_cfg_pkg::POS_SEC_HI:
                                         strap_cfg_pkg::POS_SEC_LO]);
            host_port_eeprom_autoinit <=
                secondary_bus_address_in[strap_cfg_pkg::POS_AUTOINIT];
            atm_cell_port_enable   <= secondary_bus_address_in[strap_cfg_pkg::POS_ATM];
            serial_port_one_enable <= ~secondary_bus_address_in[strap_cfg_pkg::POS_ATM];
            // Any of the three two-bit fields at its reserved code raises the flag
            strap_reserved <= is_rsvd(secondary_bus_address_in[strap_cfg_pkg::POS_BOOT_HI:
                                                                strap_cfg_pkg::POS_BOOT_LO])
                            | is_rsvd(secondary_bus_address_in[strap_cfg_pkg::POS_PRI_HI:
                                                                strap_cfg_pkg::POS_PRI_LO])
                            | is_rsvd(secondary_bus_address_in[strap_cfg_pkg::POS_SEC_HI:
                                                                strap_cfg_pkg::POS_SEC_LO]);
        end
    end

    // Control and address registers written by software
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive_q <= strap_cfg_pkg::CTRL_DRIVE_RST;
            addr_q  <= strap_cfg_pkg::ADDR_RST;
        end else if (reg_wr) begin
            if (reg_addr == strap_cfg_pkg::REG_CTRL)
                drive_q <= reg_wdata[strap_cfg_pkg::CTRL_DRIVE];
            if (reg_addr == strap_cfg_pkg::REG_ADDR)
                addr_q <= reg_wdata[19:0];
        end
    end

    // Pin drivers: floated in reset, driven with the half-word address after it while drive_q is set
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            secondary_bus_address_oe  <= 1'b0;
            secondary_bus_address_out <= strap_cfg_pkg::ADDR_RST;
        end else begin
            secondary_bus_address_oe  <= drive_q;
            secondary_bus_address_out <= addr_q;
        end
    end

    // Read data, valid the cycle after the read strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= strap_cfg_pkg::RD_ZERO;
        end else begin
            reg_rdata <= strap_cfg_pkg::RD_ZERO;
            if (reg_rd) begin
                case (reg_addr)
                    strap_cfg_pkg::REG_STATUS: begin
                        reg_rdata[strap_cfg_pkg::ST_ENDIAN] <= little_endian;
                        reg_rdata[strap_cfg_pkg::ST_BOOT_LO +: 2] <= boot_mode;
                        reg_rdata[strap_cfg_pkg::ST_PRI_LO +: 2] <= primary_bus_clock_source_sel;
                        reg_rdata[strap_cfg_pkg::ST_SEC_LO +: 2] <=
                            secondary_bus_clock_source_sel;
                        reg_rdata[strap_cfg_pkg::ST_AUTOINIT] <= host_port_eeprom_autoinit;
                        reg_rdata[strap_cfg_pkg::ST_ATM] <= atm_cell_port_enable;
                        reg_rdata[strap_cfg_pkg::ST_RSVD] <= strap_reserved;
                    end
                    strap_cfg_pkg::REG_CTRL: begin
                        reg_rdata[strap_cfg_pkg::CTRL_DRIVE] <= drive_q;
                    end
                    strap_cfg_pkg::REG_ADDR: begin
                        reg_rdata[19:0] <= addr_q;
                    end
                    default: begin
                        reg_rdata <= strap_cfg_pkg::RD_ZERO;
                    end
                endcase
            end
        end
    end

    // Checks on the pins and the captured straps
    chk_pins_float_reset: assert property (@(posedge clk)
        sys_rst |=> !secondary_bus_address_oe)
        else $error("address pins driven during reset");
    chk_pins_drive_after: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |=> secondary_bus_address_oe)
        else $error("address pins not driven after reset");
    chk_endian_capture: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> little_endian == $past(secondary_bus_address_in[20]))
        else $error("byte order not captured from bit 20");
    chk_boot_capture: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> boot_mode == $past(secondary_bus_address_in[19:18]))
        else $error("boot source not captured from bits 19:18");
    chk_pri_clk_capture: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |->
        primary_bus_clock_source_sel == $past(secondary_bus_address_in[17:16]))
        else $error("primary clock select not captured");
    chk_sec_clk_capture: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |->
        secondary_bus_clock_source_sel == $past(secondary_bus_address_in[15:14]))
        else $error("secondary clock select not captured");
    chk_autoinit_capture: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> host_port_eeprom_autoinit == $past(secondary_bus_address_in[13]))
        else $error("auto-initialisation not captured from bit 13");
    chk_atm_port_excl: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> atm_cell_port_enable == $past(secondary_bus_address_in[11])
        && serial_port_one_enable != atm_cell_port_enable)
        else $error("cell port and serial port one not exclusive");
    chk_straps_held: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) |-> $stable(boot_mode) && $stable(little_endian)
        && $stable(atm_cell_port_enable) && $stable(primary_bus_clock_source_sel)
        && $stable(secondary_bus_clock_source_sel))
        else $error("straps changed outside reset");

    // Flags that the held check above leaves out must not move either
    chk_flags_held: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) |-> $stable(host_port_eeprom_autoinit)
        && $stable(serial_port_one_enable) && $stable(strap_reserved))
        else $error("strap flags changed outside reset");

    // Reserved flag taken from the same pin sample as the fields
    chk_rsvd_capture: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> strap_reserved == (($past(secondary_bus_address_in[19:18]) == 2'h3)
        || ($past(secondary_bus_address_in[17:16]) == 2'h3)
        || ($past(secondary_bus_address_in[15:14]) == 2'h3)))
        else $error("reserved flag not captured");

    // Cell port and serial port one never both on, nor both off
    chk_ports_exclusive: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) |-> serial_port_one_enable != atm_cell_port_enable)
        else $error("cell port and serial port one enables agree");

    // Address output parked at its reset value while straps are sampled
    chk_pins_out_reset: assert property (@(posedge clk)
        sys_rst |=> secondary_bus_address_out == strap_cfg_pkg::ADDR_RST)
        else $error("address output not parked during reset");

    // Pin enable follows the drive control one cycle later
    chk_oe_follows_ctrl: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst |=> secondary_bus_address_oe == $past(drive_q))
        else $error("pin enable does not follow drive control");

    // Pins carry the programmed half-word address one cycle later
    chk_addr_follows_reg: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst |=> secondary_bus_address_out == $past(addr_q))
        else $error("address pins do not follow address register");

    // Read data stands for one cycle only and is zero otherwise
    chk_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == strap_cfg_pkg::RD_ZERO)
        else $error("read data not zero without a read");

    // Status read returns the captured byte order, cell port, auto-initialisation and reserved bits
    chk_status_read: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == strap_cfg_pkg::REG_STATUS |=>
        reg_rdata[strap_cfg_pkg::ST_ENDIAN] == $past(little_endian)
        && reg_rdata[strap_cfg_pkg::ST_ATM] == $past(atm_cell_port_enable)
        && reg_rdata[strap_cfg_pkg::ST_AUTOINIT] == $past(host_port_eeprom_autoinit)
        && reg_rdata[strap_cfg_pkg::ST_RSVD] == $past(strap_reserved))
        else $error("status read does not match captured straps");

    // Control read returns the drive enable
    chk_ctrl_read: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == strap_cfg_pkg::REG_CTRL |=>
        reg_rdata == {31'h0, $past(drive_q)})
        else $error("control read does not match drive enable");

    // Address read returns the programmed half-word address
    chk_addr_read: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == strap_cfg_pkg::REG_ADDR |=>
        reg_rdata == {12'h0, $past(addr_q)})
        else $error("address read does not match address register");

    // Unmapped addresses read as zero
    chk_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr != strap_cfg_pkg::REG_STATUS
        && reg_addr != strap_cfg_pkg::REG_CTRL
        && reg_addr != strap_cfg_pkg::REG_ADDR |=>
        reg_rdata == strap_cfg_pkg::RD_ZERO)
        else $error("unmapped read not zero");

    // Release always hands the pins back to the drive enable reset value
    chk_oe_reset_value: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> drive_q == strap_cfg_pkg::CTRL_DRIVE_RST)
        else $error("drive enable not at its reset value on release");
endmodule

// file: verilog/strap_cfg_pkg.sv
// Constants for the reset strap configuration latch
package strap_cfg_pkg;
    // Secondary bus address pin range (half-word address)
    localparam int ADDR_MSB = 20;
    localparam int ADDR_LSB = 1;
    // Strap field positions on the address pins
    localparam int POS_ENDIAN    = 20;
    localparam int POS_BOOT_HI   = 19;
    localparam int POS_BOOT_LO   = 18;
    localparam int POS_PRI_HI    = 17;
    localparam int POS_PRI_LO    = 16;
    localparam int POS_SEC_HI    = 15;
    localparam int POS_SEC_LO    = 14;
    localparam int POS_AUTOINIT  = 13;
    localparam int POS_ATM       = 11;
    // Boot source codes
    typedef enum logic [1:0] {
        BOOT_NONE     = 2'h0,
        BOOT_HOST     = 2'h1,
        BOOT_ROM8     = 2'h2,
        BOOT_RESERVED = 2'h3
    } boot_mode_t;
    // Memory interface clock source codes
    typedef enum logic [1:0] {
        CLK_EXT_IN   = 2'h0,
        CLK_CPU_DIV4 = 2'h1,
        CLK_CPU_DIV6 = 2'h2,
        CLK_RESERVED = 2'h3
    } clk_sel_t;
    // Register map (byte addresses)
    localparam int          REG_AW      = 4;
    localparam logic [3:0]  REG_STATUS  = 4'h0;
    localparam logic [3:0]  REG_CTRL    = 4'h4;
    localparam logic [3:0]  REG_ADDR    = 4'h8;
    // Status register layout
    localparam int ST_ENDIAN   = 0;
    localparam int ST_BOOT_LO  = 1;
    localparam int ST_PRI_LO   = 3;
    localparam int ST_SEC_LO   = 5;
    localparam int ST_AUTOINIT = 7;
    localparam int ST_ATM      = 8;
    localparam int ST_RSVD     = 9;
    // Control register layout and reset value
    localparam int          CTRL_DRIVE     = 0;
    localparam logic        CTRL_DRIVE_RST = 1'b1;
    localparam logic [19:0] ADDR_RST       = 20'h00000;
    localparam logic [31:0] RD_ZERO        = 32'h00000000;
endpackage
